// *** hdl/serial_flash_status_and_protection.sv ***
// Purpose: status registers and array protection of a serial NOR flash behind its serial pins
// Assumes: serial clock well below mclk/4, sampled by mclk through two flip-flops
// Notes: non-volatile fields take their defaults at reset_n, which stands for a power cycle
`timescale 1ns/1ns
`default_nettype none
module serial_flash_status_and_protection #(
  parameter int PROGRAM_CYCLES = 2000,
  parameter int ERASE_CYCLES = 8000,
  parameter int STATUS_WRITE_CYCLES = 500
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_n,
  output logic so,
  output logic so_oe,
  output logic busy,
  output logic hold_active,
  output logic quad_enable,
  output logic [1:0] drive_strength,
  output logic [2:0] security_locks,
  output logic [3:0] dual_io_dummy_cycles,
  output logic [3:0] quad_io_dummy_cycles
);
  import flash_status_pkg::*;

  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sclk_last;
  logic cs_last;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic [2:0] bit_idx;
  logic [COUNT_W-1:0] total;
  logic [7:0] cmd;
  logic [7:0] wdata;
  logic [ADDR_W-1:0] addr;
  logic write_enable_latch;
  logic [4:0] block_protect_field;
  logic protect_complement;
  logic protect_method_hi;
  logic protect_method_lo;
  logic dummy_config;
  logic erase_suspended;
  logic program_suspended;
  logic reset_armed;
  op_type op;
  logic [BUSY_W-1:0] busy_count;
  logic busy_flag;
  logic suspended;
  logic framed;
  logic single_byte;
  logic is_status_write;
  logic is_program;
  logic is_erase;
  logic is_chip_erase;
  logic write_type;
  logic accept;
  logic status_locked;
  logic chip_erase_ok;
  logic [ADDR_W-1:0] erase_span;
  logic go_status;
  logic go_program;
  logic go_erase;
  logic exec_suspend;
  logic exec_resume;
  logic soft_reset;
  logic [7:0] read_byte;
  logic reading;

  function automatic logic region_protected(
    input logic [4:0] bp,
    input logic comp,
    input logic [ADDR_W-1:0] a
  );
    logic [7:0] blk;
    logic [4:0] sec;
    logic [7:0] nblk;
    logic [4:0] nsec;
    logic base;
    blk = {1'h0, a[BLOCK_MSB:BLOCK_LSB]};
    sec = {1'h0, a[SECTOR_MSB:SECTOR_LSB]};
    nblk = 8'h01 << bp[2:0];
    nsec = 5'h01 << (bp[2] ? SECTOR_SHIFT_MAX : {1'h0, bp[1:0] - 2'h1});
    if (bp[2:0] == BP_LOW_NONE)
    begin
      base = 1'h0;
    end
    else if (bp[2:0] == BP_LOW_ALL)
    begin
      base = 1'h1;
    end
    else if (!bp[4])
    begin
      base = bp[3] ? (blk < nblk) : (blk >= BLOCK_COUNT - nblk);
    end
    else if (bp[3])
    begin
      base = (blk[6:0] == BLOCK_FIRST) && (sec < nsec);
    end
    else
    begin
      base = (blk[6:0] == BLOCK_LAST) && (sec >= SECTORS_PER_BLOCK - nsec);
    end
    // the complemented map is the exact inverse of the plain one
    return base ^ comp;
  endfunction : region_protected

  // pins come from another clock domain
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      sclk_last <= 1'h1;
      cs_last <= 1'h1;
    end
    else
    begin
      pin_meta <= {hold_n, wp_n, si, sclk, cs_n};
      pin_sync <= pin_meta;
      sclk_last <= pin_sync[PIN_SCLK];
      cs_last <= pin_sync[PIN_CS];
    end
  end

  // with quad enable set the hold pin is only a data line
  assign hold_active = !quad_enable && !pin_sync[PIN_HOLD] && !pin_sync[PIN_CS];
  assign sclk_rise = pin_sync[PIN_SCLK] && !sclk_last && !pin_sync[PIN_CS] && !hold_active;
  assign sclk_fall = !pin_sync[PIN_SCLK] && sclk_last && !pin_sync[PIN_CS] && !hold_active;
  assign cs_rise = pin_sync[PIN_CS] && !cs_last;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_idx <= 3'h0;
      total <= '0;
      cmd <= 8'h00;
      wdata <= 8'h00;
      addr <= '0;
    end
    else if (pin_sync[PIN_CS])
    begin
      bit_idx <= 3'h0;
      total <= '0;
    end
    else if (sclk_rise)
    begin
      bit_idx <= bit_idx + 3'h1;
      if (total != COUNT_MAX)
      begin
        total <= total + 6'h01;
      end
      if (total < BITS_CMD)
      begin
        cmd <= {cmd[6:0], pin_sync[PIN_SI]};
      end
      else if (total < BITS_ERASE)
      begin
        addr <= {addr[ADDR_W-2:0], pin_sync[PIN_SI]};
      end
      if (total >= BITS_CMD && total < BITS_STATUS_WRITE)
      begin
        wdata <= {wdata[6:0], pin_sync[PIN_SI]};
      end
    end
  end

  // commands act only when chip select rises on a byte boundary
  assign framed = cs_rise && (bit_idx == 3'h0);
  assign single_byte = framed && (total == BITS_CMD);
  assign busy_flag = (op != OP_IDLE) && !suspended;
  assign suspended = erase_suspended || program_suspended;
  assign busy = busy_flag;

  always_comb
  begin
    is_status_write = (total == BITS_STATUS_WRITE) &&
      (cmd == CMD_WRITE_STATUS_1 || cmd == CMD_WRITE_STATUS_2 || cmd == CMD_WRITE_STATUS_3);
    is_program = (total >= BITS_PROGRAM_MIN) && (cmd == CMD_PAGE_PROGRAM || cmd == CMD_QUAD_PAGE_PROGRAM);
    is_chip_erase = (total == BITS_CMD) && (cmd == CMD_CHIP_ERASE_A || cmd == CMD_CHIP_ERASE_B);
    is_erase = total == BITS_ERASE;
    case (cmd)
      CMD_SECTOR_ERASE: erase_span = SPAN_SECTOR;
      CMD_BLOCK_ERASE_32K: erase_span = SPAN_BLOCK_32K;
      CMD_BLOCK_ERASE_64K: erase_span = SPAN_BLOCK_64K;
      default:
      begin
        erase_span = '0;
        is_erase = 1'h0;
      end
    endcase
  end

  // the write-protect pin counts only while it is not a data line
  always_comb
  begin
    case ({protect_method_hi, protect_method_lo})
      METHOD_SOFTWARE: status_locked = 1'h0;
      METHOD_HARDWARE: status_locked = !quad_enable && !pin_sync[PIN_WP];
      METHOD_LOCKDOWN: status_locked = 1'h1;
      METHOD_ONE_TIME: status_locked = 1'h1;
      default: status_locked = 1'h1;
    endcase
  end

  assign chip_erase_ok = (block_protect_field[2:0] == BP_LOW_NONE && !protect_complement) ||
    (block_protect_field[2:0] == BP_LOW_ALL && protect_complement);
  assign write_type = framed && (op == OP_IDLE) &&
    (is_status_write || is_program || is_erase || is_chip_erase);
  assign accept = write_type && write_enable_latch;
  assign go_status = accept && is_status_write && !status_locked;
  assign go_program = accept && is_program &&
    !region_protected(block_protect_field, protect_complement, addr);
  // both ends of the erase unit are checked so partial overlap is refused
  assign go_erase = accept && ((is_erase &&
    !region_protected(block_protect_field, protect_complement, addr & ~erase_span) &&
    !region_protected(block_protect_field, protect_complement, addr | erase_span)) ||
    (is_chip_erase && chip_erase_ok));
  assign exec_suspend = single_byte && (cmd == CMD_SUSPEND) && busy_flag && (op != OP_STATUS);
  assign exec_resume = single_byte && (cmd == CMD_RESUME) && suspended;
  assign soft_reset = single_byte && (cmd == CMD_RESET) && reset_armed;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_armed <= 1'h0;
    end
    else if (cs_rise)
    begin
      reset_armed <= single_byte && (cmd == CMD_RESET_ENABLE);
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_enable_latch <= 1'h0;
    end
    else if (soft_reset || write_type || (single_byte && cmd == CMD_WRITE_DISABLE))
    begin
      write_enable_latch <= 1'h0;
    end
    else if (single_byte && cmd == CMD_WRITE_ENABLE && !busy_flag)
    begin
      write_enable_latch <= 1'h1;
    end
  end

  // suspended operations keep their remaining count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op <= OP_IDLE;
      busy_count <= '0;
    end
    else if (soft_reset)
    begin
      op <= OP_IDLE;
      busy_count <= '0;
    end
    else if (go_status)
    begin
      op <= OP_STATUS;
      busy_count <= BUSY_W'(STATUS_WRITE_CYCLES);
    end
    else if (go_program)
    begin
      op <= OP_PROGRAM;
      busy_count <= BUSY_W'(PROGRAM_CYCLES);
    end
    else if (go_erase)
    begin
      op <= OP_ERASE;
      busy_count <= BUSY_W'(ERASE_CYCLES);
    end
    else if (busy_flag)
    begin
      busy_count <= busy_count - BUSY_ONE;
      if (busy_count <= BUSY_ONE)
      begin
        op <= OP_IDLE;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      erase_suspended <= 1'h0;
      program_suspended <= 1'h0;
    end
    else if (soft_reset || exec_resume)
    begin
      erase_suspended <= 1'h0;
      program_suspended <= 1'h0;
    end
    else if (exec_suspend)
    begin
      erase_suspended <= op == OP_ERASE;
      program_suspended <= op == OP_PROGRAM;
    end
  end

  // only writable fields change; busy, latch and suspend flags live elsewhere
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      block_protect_field <= BP_RESET;
      protect_method_lo <= 1'h0;
      protect_method_hi <= 1'h0;
      protect_complement <= 1'h0;
      quad_enable <= 1'h0;
      security_locks <= LOCK_RESET;
      dummy_config <= 1'h0;
      drive_strength <= DRIVE_RESET;
    end
    else if (go_status)
    begin
      case (cmd)
        CMD_WRITE_STATUS_1:
        begin
          block_protect_field <= wdata[BP_MSB:BP_LSB];
          protect_method_lo <= wdata[METHOD_LO_BIT];
        end
        CMD_WRITE_STATUS_2:
        begin
          protect_method_hi <= wdata[METHOD_HI_BIT];
          quad_enable <= wdata[QUAD_BIT];
          protect_complement <= wdata[COMPLEMENT_BIT];
          security_locks <= security_locks | wdata[LOCK_MSB:LOCK_LSB];
        end
        CMD_WRITE_STATUS_3:
        begin
          dummy_config <= wdata[DUMMY_BIT];
          drive_strength <= wdata[DRIVE_MSB:DRIVE_LSB];
        end
        default:
        begin
          block_protect_field <= block_protect_field;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dual_io_dummy_cycles <= DUAL_DUMMY_SHORT;
      quad_io_dummy_cycles <= QUAD_DUMMY_SHORT;
    end
    else
    begin
      dual_io_dummy_cycles <= dummy_config ? DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT;
      quad_io_dummy_cycles <= dummy_config ? QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT;
    end
  end

  // reserved bits read as zero
  always_comb
  begin
    read_byte = 8'h00;
    reading = total >= BITS_CMD;
    case (cmd)
      CMD_READ_STATUS_1:
      begin
        read_byte[BUSY_BIT] = busy_flag;
        read_byte[WEL_BIT] = write_enable_latch;
        read_byte[BP_MSB:BP_LSB] = block_protect_field;
        read_byte[METHOD_LO_BIT] = protect_method_lo;
      end
      CMD_READ_STATUS_2:
      begin
        read_byte[METHOD_HI_BIT] = protect_method_hi;
        read_byte[QUAD_BIT] = quad_enable;
        read_byte[PROG_SUSP_BIT] = program_suspended;
        read_byte[LOCK_MSB:LOCK_LSB] = security_locks;
        read_byte[COMPLEMENT_BIT] = protect_complement;
        read_byte[ERASE_SUSP_BIT] = erase_suspended;
      end
      CMD_READ_STATUS_3:
      begin
        read_byte[DUMMY_BIT] = dummy_config;
        read_byte[DRIVE_MSB:DRIVE_LSB] = drive_strength;
      end
      default:
      begin
        reading = 1'h0;
      end
    endcase
  end

  // bits leave on falling edges, msb first; ~bit_idx is 7 minus the index
  // the byte is sampled live, so busy can clear mid-read within the byte being sent
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      so <= 1'h0;
      so_oe <= 1'h0;
    end
    else if (pin_sync[PIN_CS] || !reading || hold_active)
    begin
      so_oe <= 1'h0;
    end
    else if (sclk_fall)
    begin
      so <= read_byte[~bit_idx];
      so_oe <= 1'h1;
    end
  end
endmodule : serial_flash_status_and_protection
`default_nettype wire

// *** hdl/flash_status_pkg.sv ***
// Purpose: constants shared by the status and protection block of a serial NOR flash
// Assumes: 8 MB array, 64 KB blocks of sixteen 4 KB sectors
// Notes: command codes and status bit positions as seen on the serial link
package flash_status_pkg;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS_1 = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_2 = 8'h35;
  localparam logic [7:0] CMD_READ_STATUS_3 = 8'h15;
  localparam logic [7:0] CMD_WRITE_STATUS_1 = 8'h01;
  localparam logic [7:0] CMD_WRITE_STATUS_2 = 8'h31;
  localparam logic [7:0] CMD_WRITE_STATUS_3 = 8'h11;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE_32K = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE_64K = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;

  // frame lengths in serial clock edges
  localparam int COUNT_W = 6;
  localparam logic [COUNT_W-1:0] BITS_CMD = 6'h08;
  localparam logic [COUNT_W-1:0] BITS_STATUS_WRITE = 6'h10;
  localparam logic [COUNT_W-1:0] BITS_ERASE = 6'h20;
  localparam logic [COUNT_W-1:0] BITS_PROGRAM_MIN = 6'h28;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 6'h3F;

  // synchronised pin vector layout
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_HOLD = 4;
  localparam logic [4:0] PIN_IDLE = 5'h1F;

  // status byte 1
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int BP_LSB = 2;
  localparam int BP_MSB = 6;
  localparam int METHOD_LO_BIT = 7;
  // status byte 2
  localparam int METHOD_HI_BIT = 0;
  localparam int QUAD_BIT = 1;
  localparam int PROG_SUSP_BIT = 2;
  localparam int LOCK_LSB = 3;
  localparam int LOCK_MSB = 5;
  localparam int COMPLEMENT_BIT = 6;
  localparam int ERASE_SUSP_BIT = 7;
  // status byte 3
  localparam int DUMMY_BIT = 0;
  localparam int DRIVE_LSB = 5;
  localparam int DRIVE_MSB = 6;

  // reset values
  localparam logic [4:0] BP_RESET = 5'h00;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h1;

  // protect method codes {hi, lo}
  localparam logic [1:0] METHOD_SOFTWARE = 2'h0;
  localparam logic [1:0] METHOD_HARDWARE = 2'h1;
  localparam logic [1:0] METHOD_LOCKDOWN = 2'h2;
  localparam logic [1:0] METHOD_ONE_TIME = 2'h3;

  // array geometry and protection decoding
  localparam int ADDR_W = 24;
  localparam int BLOCK_LSB = 16;
  localparam int BLOCK_MSB = 22;
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_MSB = 15;
  localparam logic [7:0] BLOCK_COUNT = 8'h80;
  localparam logic [6:0] BLOCK_FIRST = 7'h00;
  localparam logic [6:0] BLOCK_LAST = 7'h7F;
  localparam logic [4:0] SECTORS_PER_BLOCK = 5'h10;
  localparam logic [2:0] BP_LOW_NONE = 3'h0;
  localparam logic [2:0] BP_LOW_ALL = 3'h7;
  localparam logic [2:0] SECTOR_SHIFT_MAX = 3'h3;
  localparam logic [ADDR_W-1:0] SPAN_SECTOR = 24'h000FFF;
  localparam logic [ADDR_W-1:0] SPAN_BLOCK_32K = 24'h007FFF;
  localparam logic [ADDR_W-1:0] SPAN_BLOCK_64K = 24'h00FFFF;

  // read latency
  localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_LONG = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_LONG = 4'hA;

  localparam int BUSY_W = 24;
  localparam logic [BUSY_W-1:0] BUSY_ONE = 24'h000001;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE,
    OP_STATUS
  } op_type;
endpackage : flash_status_pkg

// *** testbench/flash_host_model.sv ***
// Purpose: serial host driving the flash pins with framed commands
// Assumes: mode 0, msb first, 320 ns serial clock
// Notes: clock stands low between frames; si shows the inverse of its last bit when not meaningful
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // tx is left aligned; rbits more edges shift so in, sampled late in the high phase
  task automatic xfer(input logic [39:0] tx, input int nbits, input int rbits, output logic [7:0] rx,
                      output logic oe);
    rx = 8'h00;
    oe = 1'b1;
    #7 cs_n = 1'b0;
    for (int i = 0; i < nbits + rbits; i++)
    begin
      si = (i < nbits) ? tx[39-i] : ~si;
      #160 sclk = 1'b1;
      #150;
      if (i >= nbits)
      begin
        rx = {rx[6:0], so};
        oe = oe & so_oe;
      end
      #10 sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    si = ~si;
    // frame length stays a multiple of 40 ns, so pins always move at one mclk phase
    #193;
  endtask : xfer
endmodule : flash_host_model
`default_nettype wire

// *** testbench/serial_flash_status_and_protection_chk.sv ***
// Purpose: port assertions for the flash status and protection block
// Assumes: sees top ports only
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module serial_flash_status_and_protection_chk #(
  parameter int ERASE_CYCLES = 8000
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic hold_active,
  input wire logic quad_enable,
  input wire logic [1:0] drive_strength,
  input wire logic [2:0] security_locks,
  input wire logic [3:0] dual_io_dummy_cycles,
  input wire logic [3:0] quad_io_dummy_cycles
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  int run;
  // suspend drops busy, so the count restarts on resume
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      run <= 0;
    else
      run <= busy ? run + 1 : 0;
  sequence busy_run;
    busy [*8];
  endsequence
  AST_DEFAULTS: assert property ($rose(reset_n) |-> !quad_enable && drive_strength == 2'h1 &&
    security_locks == 3'h0) else $error("defaults wrong after reset");
  AST_DUMMY: assert property ((dual_io_dummy_cycles == 4'h4 && quad_io_dummy_cycles == 4'h6) ||
    (dual_io_dummy_cycles == 4'h8 && quad_io_dummy_cycles == 4'hA)) else $error("dummy counts mismatch");
  AST_LOCK: assert property ((security_locks & $past(security_locks)) == $past(security_locks))
    else $error("lock bit cleared");
  AST_QUAD_HOLD: assert property (quad_enable |-> !hold_active)
    else $error("hold active with quad enable");
  AST_HOLD_OE: assert property (hold_active |=> !so_oe)
    else $error("output driven during hold");
  AST_BUSY_MIN: assert property ($rose(busy) |-> busy_run)
    else $error("busy too short");
  AST_BUSY_MAX: assert property (run <= ERASE_CYCLES + 2)
    else $error("busy too long");
  AST_BUSY_FRAME: assert property ($rose(busy) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("busy rose inside a frame");
  AST_NV_FRAME: assert property (($changed(quad_enable) || $changed(drive_strength) ||
    $changed(security_locks)) |-> $past(cs_n) && $past(cs_n, 2)) else $error("field changed inside a frame");
endmodule : serial_flash_status_and_protection_chk
bind serial_flash_status_and_protection serial_flash_status_and_protection_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .mclk, .reset_n, .cs_n, .so_oe, .busy, .hold_active, .quad_enable, .drive_strength, .security_locks,
  .dual_io_dummy_cycles, .quad_io_dummy_cycles);
`default_nettype wire

// *** testbench/tb_serial_flash_status_and_protection.sv ***
// Purpose: self-checking bench for the flash status and protection block
// Assumes: busy times shortened through parameters
// Notes: random protect codes and addresses from a fixed xorshift seed, corners first
`timescale 1ns/1ns
`default_nettype none
module tb_serial_flash_status_and_protection;
  import flash_status_pkg::*;
  logic mclk, reset_n, sclk, cs_n, si, wp_n, hold_n, so, so_oe, busy, hold_active, quad_enable, oe, cmp;
  logic [1:0] drive_strength;
  logic [2:0] security_locks;
  logic [3:0] dual_io_dummy_cycles, quad_io_dummy_cycles;
  logic [31:0] rnd = 32'hADBBC227;
  logic [7:0] rx;
  logic [4:0] bp;
  logic [23:0] a;
  logic [29:0] corner [6] = '{{5'h01, 1'b1, 24'h7E0000}, {5'h01, 1'b1, 24'h7DF000}, {5'h11, 1'b1, 24'h7FF000},
    {5'h07, 1'b1, 24'h000000}, {5'h00, 1'b0, 24'h7FF000}, {5'h16, 1'b0, 24'h7F8000}};
  int fails = 0;
  int tests_run = 0;
  serial_flash_status_and_protection #(.PROGRAM_CYCLES(400), .ERASE_CYCLES(800), .STATUS_WRITE_CYCLES(20)) dut_u (
    .mclk, .reset_n, .sclk, .cs_n, .si, .wp_n, .hold_n, .so, .so_oe, .busy, .hold_active, .quad_enable,
    .drive_strength, .security_locks, .dual_io_dummy_cycles, .quad_io_dummy_cycles);
  flash_host_model host_u (.sclk, .cs_n, .si, .so, .so_oe);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xorshift
  // whether address a lies in the area the protect code guards
  function automatic logic guarded(input logic [4:0] p, input logic c, input logic [23:0] x);
    logic [23:0] size;
    logic hit;
    size = p[4] ? (24'h001000 << ((p[2:0] > 3'h4) ? 3'h3 : p[2:0] - 3'h1)) : (24'h010000 << p[2:0]);
    hit = p[3] ? (x < size) : (x >= 24'h800000 - size);
    if (p[2:0] == 3'h0)
      hit = 1'b0;
    if (p[2:0] == 3'h7)
      hit = 1'b1;
    return hit ^ c;
  endfunction : guarded
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic cmd(input logic [7:0] c);
    host_u.xfer({c, 32'h0}, 8, 0, rx, oe);
  endtask : cmd
  task automatic rd(input logic [7:0] c);
    host_u.xfer({c, 32'h0}, 8, 8, rx, oe);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd(CMD_WRITE_ENABLE);
    host_u.xfer({c, d, 24'h0}, 16, 0, rx, oe);
  endtask : wr
  // busy must have started or not, then the operation is let run out
  task automatic settle(input logic exp, input string what);
    int n;
    cyc(6);
    check(busy === exp, what);
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      cyc(1);
      n++;
    end
    // a busy flag that never drops must not slip through as a pass
    check(busy === 1'b0, "busy stuck");
  endtask : settle
  task automatic rst;
    reset_n = 1'b0;
    cyc(6);
    reset_n = 1'b1;
    cyc(4);
  endtask : rst
  task automatic hold_probe(input logic exp);
    logic seen;
    seen = 1'b0;
    fork
      rd(CMD_READ_STATUS_2);
      begin
        cyc(20);
        hold_n = 1'b0;
        repeat (8)
        begin
          cyc(1);
          seen = seen | hold_active;
        end
        hold_n = 1'b1;
      end
    join
    check(seen === exp, "hold");
  endtask : hold_probe
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    #4000000;
    fails++;
    stop_test;
  end
  initial
  begin
    wp_n = 1'b1;
    hold_n = 1'b1;
    rst;
    rd(CMD_READ_STATUS_1);
    check(rx === 8'h00 && oe === 1'b1, "sr1 reset");
    rd(CMD_READ_STATUS_2);
    check(rx === 8'h00, "sr2 reset");
    rd(CMD_READ_STATUS_3);
    check(rx === 8'h20 && drive_strength === 2'h1, "sr3 reset");
    $display("defaults done");
    host_u.xfer({CMD_WRITE_STATUS_1, 8'h1C, 24'h0}, 16, 0, rx, oe);
    settle(1'b0, "write without latch");
    cmd(CMD_WRITE_ENABLE);
    rd(CMD_READ_STATUS_1);
    check(rx === 8'h02, "latch set");
    cmd(CMD_WRITE_DISABLE);
    rd(CMD_READ_STATUS_1);
    check(rx === 8'h00, "latch cleared");
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_RESET_ENABLE);
    cmd(CMD_RESET);
    rd(CMD_READ_STATUS_1);
    check(rx === 8'h00, "soft reset latch");
    $display("latch done");
    for (int m = 0; m < 4; m++)
    begin
      wr(CMD_WRITE_STATUS_1, {m[0], 7'h00});
      settle(1'b1, "method low");
      wr(CMD_WRITE_STATUS_2, {7'h00, m[1]});
      settle(1'b1, "method high");
      wp_n = 1'b0;
      wr(CMD_WRITE_STATUS_1, {m[0], 7'h14});
      settle(m == 0, "write with pin low");
      wp_n = 1'b1;
      wr(CMD_WRITE_STATUS_1, {m[0], 7'h18});
      settle(m < 2, "write with pin high");
      rd(CMD_READ_STATUS_1);
      check(rx === {m[0], (m < 2) ? 7'h18 : 7'h00}, "sr1 after method");
      rst;
      rd(CMD_READ_STATUS_2);
      check(rx === 8'h00, "method after power cycle");
    end
    $display("methods done");
    for (int i = 0; i < 14; i++)
    begin
      rnd = xorshift(rnd);
      {bp, cmp, a} = (i < 6) ? corner[i] : {rnd[4:0], rnd[5], 1'b0, rnd[31:21], 12'h000};
      wr(CMD_WRITE_STATUS_1, {1'b0, bp, 2'b00});
      settle(1'b1, "bp write");
      wr(CMD_WRITE_STATUS_2, {1'b0, cmp, 6'h00});
      settle(1'b1, "cmp write");
      rd(CMD_READ_STATUS_1);
      check(rx === {1'b0, bp, 2'b00}, "bp readback");
      cmd(CMD_WRITE_ENABLE);
      host_u.xfer({CMD_SECTOR_ERASE, a, 8'h00}, 32, 0, rx, oe);
      settle(!guarded(bp, cmp, a), "sector erase");
      cmd(CMD_WRITE_ENABLE);
      host_u.xfer({CMD_PAGE_PROGRAM, a + 24'h000100, 8'hA5}, 40, 0, rx, oe);
      settle(!guarded(bp, cmp, a), "program");
      cmd(CMD_WRITE_ENABLE);
      cmd(i[0] ? CMD_CHIP_ERASE_B : CMD_CHIP_ERASE_A);
      settle((bp[2:0] == 3'h0 && !cmp) || (bp[2:0] == 3'h7 && cmp), "chip erase");
      rd(CMD_READ_STATUS_1);
      check(rx[1:0] === 2'b00, "latch after erase");
    end
    $display("protection done");
    rst;
    for (int d = 0; d < 4; d++)
    begin
      wr(CMD_WRITE_STATUS_3, {1'b0, d[1:0], 4'h0, d[0]});
      settle(1'b1, "sr3 write");
      rd(CMD_READ_STATUS_3);
      check(rx === {1'b0, d[1:0], 4'h0, d[0]} && drive_strength === d[1:0], "drive");
      check(dual_io_dummy_cycles === (d[0] ? 4'h8 : 4'h4) && quad_io_dummy_cycles === (d[0] ? 4'hA : 4'h6),
        "dummy");
    end
    wr(CMD_WRITE_STATUS_2, 8'h2A);
    settle(1'b1, "sr2 write");
    check(security_locks === 3'h5 && quad_enable === 1'b1, "locks and quad");
    wr(CMD_WRITE_STATUS_2, 8'h50);
    settle(1'b1, "sr2 write");
    rd(CMD_READ_STATUS_2);
    check(rx === 8'h78, "locks gather");
    hold_probe(1'b1);
    wr(CMD_WRITE_STATUS_2, 8'h02);
    settle(1'b1, "sr2 write");
    rd(CMD_READ_STATUS_2);
    check(rx === 8'h3A, "locks kept");
    hold_probe(1'b0);
    $display("fields done");
    rst;
    for (int k = 0; k < 2; k++)
    begin
      cmd(CMD_WRITE_ENABLE);
      if (k == 0)
        host_u.xfer({CMD_SECTOR_ERASE, 24'h010000, 8'h00}, 32, 0, rx, oe);
      else
        host_u.xfer({CMD_PAGE_PROGRAM, 24'h020000, 8'h3C}, 40, 0, rx, oe);
      cmd(CMD_SUSPEND);
      rd(CMD_READ_STATUS_2);
      check(rx === ((k == 0) ? 8'h80 : 8'h04) && busy === 1'b0, "suspend flag");
      if (k == 0)
      begin
        cmd(CMD_RESUME);
        settle(1'b1, "resume");
      end
      else
        rst;
      rd(CMD_READ_STATUS_2);
      check(rx === 8'h00, "suspend cleared");
    end
    $display("suspend done");
    stop_test;
  end
endmodule : tb_serial_flash_status_and_protection
`default_nettype wire
